/* design/asr_link.sv */
// Purpose: serial link end, runs on the host's serial clock
// Assumes: mosi sampled on rising sck, miso changes on falling sck, ce high frames a transfer
// Notes: each received byte is held and announced by a toggle for the system clock side
`timescale 1ns/1ps
`default_nettype none
module asr_link
  import asr_pkg::*;
(
  input wire logic sck,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic mosi,
  input wire logic [7:0] tx_byte,
  output logic miso_out,
  output logic miso_oe_b,
  output logic [7:0] rx_byte,
  output logic rx_is_addr,
  output logic rx_tgl
);
  logic [2:0] bit_cnt_ff;
  logic [6:0] rx_sh_ff;
  logic addr_pend_ff;
  logic [7:0] tx_sh_ff;
  logic [7:0] rx_byte_ff;
  logic rx_is_addr_ff;
  logic rx_tgl_ff;
  logic frame_clr_b;

  // frame reset: ce low between frames or the block reset, so the counter never starts unknown
  assign frame_clr_b = ce & rst_b;

  // bit counter and input shifter, cleared by the frame itself since sck may stop
  always_ff @(posedge sck or negedge frame_clr_b) begin
    if (!frame_clr_b) begin
      bit_cnt_ff <= 3'h0;
      rx_sh_ff <= 7'h00;
      addr_pend_ff <= 1'b1;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      rx_sh_ff <= {rx_sh_ff[5:0], mosi};
      if (bit_cnt_ff == 3'h7) begin
        addr_pend_ff <= 1'b0;
      end
    end
  end

  // hand-off word, kept out of the frame reset so the toggle never jumps at ce fall
  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      rx_byte_ff <= 8'h00;
      rx_is_addr_ff <= 1'b0;
      rx_tgl_ff <= 1'b0;
    end else if (bit_cnt_ff == 3'h7) begin
      rx_byte_ff <= {rx_sh_ff, mosi};
      rx_is_addr_ff <= addr_pend_ff;
      rx_tgl_ff <= ~rx_tgl_ff;
    end
  end

  // output shifter; tx_byte is quasi-static, the host leaves a gap between bytes
  always_ff @(negedge sck or negedge frame_clr_b) begin
    if (!frame_clr_b) begin
      tx_sh_ff <= 8'h00;
    end else if (bit_cnt_ff == 3'h1) begin
      tx_sh_ff <= {tx_byte[6:0], 1'b0};
    end else begin
      tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
    end
  end

  // first bit of a byte comes straight from the prepared byte
  assign miso_out = (bit_cnt_ff == 3'h0) ? tx_byte[7] : tx_sh_ff[7];
  assign miso_oe_b = ~ce;
  assign rx_byte = rx_byte_ff;
  assign rx_is_addr = rx_is_addr_ff;
  assign rx_tgl = rx_tgl_ff;
endmodule
`default_nettype wire

/* design/asr_pkg.sv */
// Purpose: shared constants and types for the converter status and result sequencer
// Assumes: 8 channels, 10-bit results, address/control byte with write flag in its top bit
// Notes: register offsets are the byte values carried in the address/control byte
package asr_pkg;
  // channel and result sizes
  localparam int NCHAN = 8;
  localparam int RES_W = 10;

  // address/control byte
  localparam int RW_BIT = 7;
  localparam logic [6:0] ADDR_DATA_LAST = 7'h0f;
  localparam logic [6:0] ADDR_MODE = 7'h10;
  localparam logic [6:0] ADDR_MASK = 7'h11;
  localparam logic [6:0] ADDR_START = 7'h12;
  localparam logic [6:0] ADDR_STATUS = 7'h13;

  // mode_control_reg fields
  localparam int MODE_LSB = 0;
  localparam int IRQ_ALLOW_POS = 2;
  localparam int BYTE_SEL_POS = 3;
  localparam int VREF_POS = 4;
  localparam int OSC_SEL_POS = 5;
  localparam logic [5:0] MODE_RESET = 6'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // start_channel_reg fields
  localparam int RUN_POS = 7;
  localparam int JAM_POS = 4;
  localparam int CA_LSB = 1;
  localparam int HL_POS = 0;

  // converter_status fields
  localparam int ST_IRQ_POS = 7;
  localparam int ST_DONE_POS = 6;
  localparam int ST_BUSY_POS = 5;
  localparam int ST_PTR_LSB = 1;

  // high result byte fields
  localparam int FRESH_POS = 7;
  localparam int OVR_POS = 6;

  // conversion modes, in the order of their two-bit codes
  typedef enum logic [1:0] {CONV_IDLE, CONV_SINGLE, CONV_SCAN_ONCE, CONV_SCAN_LOOP} asr_mode_e;

  // register selected by the address/control byte of a frame
  typedef enum logic [2:0] {SEL_NONE, SEL_DATA, SEL_MODE, SEL_MASK, SEL_START, SEL_STATUS} asr_sel_e;
endpackage

/* design/asr_result_mem.sv */
// Purpose: per-channel result storage with a registered read port
// Assumes: one write and one read per clock, same clock
// Notes: read data follow the read address one clock later
`timescale 1ns/1ps
`default_nettype none
module asr_result_mem
  import asr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [RES_W-1:0] wr_data,
  input wire logic [2:0] rd_addr,
  output logic [RES_W-1:0] rd_data
);
  logic [RES_W-1:0] mem_ff [NCHAN];
  logic [RES_W-1:0] rd_data_ff;

  // array carries no reset, contents are only meaningful once fresh
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  // registered read
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= mem_ff[rd_addr];
    end
  end

  assign rd_data = rd_data_ff;
endmodule
`default_nettype wire

/* design/asr_top.sv */
// Purpose: status, result storage and conversion sequencing of a serial multichannel converter
// Assumes: converter core and this logic share clk_sys; host link runs on sck
// Notes: host leaves a gap of 16 clk_sys cycles after ce rise and between bytes
`timescale 1ns/1ps
`default_nettype none
module asr_top
  import asr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sck,
  input wire logic ce,
  input wire logic mosi,
  output logic miso_out,
  output logic miso_oe_b,
  output logic irq_n_out,
  output logic irq_n_oe_b,
  output logic conv_start,
  output logic conv_abort,
  output logic [2:0] conv_chan,
  output logic conv_byte_mode,
  output logic conv_vref_sel,
  output logic conv_clk_en,
  output logic osc_run,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_result
);
  // next active channel above cur, wrapping; stays put when nothing is active
  function automatic logic [2:0] next_chan(input logic [2:0] cur, input logic [NCHAN-1:0] en);
    logic [2:0] pick;
    logic [2:0] cand;
    logic found;
    pick = cur;
    found = 1'b0;
    for (int i = 1; i <= NCHAN; i++) begin
      cand = cur + 3'(i);
      if (!found && en[cand]) begin
        pick = cand;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  logic [7:0] rx_byte;
  logic rx_is_addr;
  logic rx_tgl;
  logic [7:0] tx_byte_ff;
  logic [1:0] sync1_ff;
  logic [1:0] sync2_ff;
  logic tgl_seen_ff;
  asr_sel_e sel_ff;
  logic wr_ff;
  logic [5:0] mode_ff;
  logic [7:0] mask_ff;
  logic run_ff;
  logic jam_rb_ff;
  logic [2:0] ca_rb_ff;
  logic [2:0] ptr_ff;
  logic hl_ff;
  logic converting_ff;
  logic start_req_ff;
  logic conv_start_ff;
  logic conv_abort_ff;
  logic [2:0] conv_chan_ff;
  logic busy_ff;
  logic irq_flag_ff;
  logic all_done_ff;
  logic [NCHAN-1:0] fresh_ff;
  logic [NCHAN-1:0] overrun_ff;
  logic irq_drive_ff;
  logic [RES_W-1:0] rd_data;
  asr_mode_e conv_mode;
  logic byte_evt, addr_evt, data_evt, wr_evt, rd_evt;
  logic mode_wr, mask_wr, start_wr, flag_wipe, run_jam_wr;
  logic status_rd, data_rd, data_rd_lo, byte8, abort_now, done_ok, all_now;
  logic [NCHAN-1:0] done_hot;
  logic [NCHAN-1:0] new_fresh;
  logic [2:0] ptr_next;

  asr_link u_link (
    .sck(sck),
    .rst_b(rst_b),
    .ce(ce),
    .mosi(mosi),
    .tx_byte(tx_byte_ff),
    .miso_out(miso_out),
    .miso_oe_b(miso_oe_b),
    .rx_byte(rx_byte),
    .rx_is_addr(rx_is_addr),
    .rx_tgl(rx_tgl)
  );

  asr_result_mem u_mem (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wr_en(done_ok),
    .wr_addr(conv_chan_ff),
    .wr_data(conv_result),
    .rd_addr(ptr_ff),
    .rd_data(rd_data)
  );

  // ce level and byte toggle cross into clk_sys through two flops each
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
      tgl_seen_ff <= 1'b0;
    end else begin
      sync1_ff <= {ce, rx_tgl};
      sync2_ff <= sync1_ff;
      tgl_seen_ff <= sync2_ff[0];
    end
  end

  // decoded events; rx_byte is stable while its toggle edge is seen
  assign conv_mode = asr_mode_e'(mode_ff[MODE_LSB+1:MODE_LSB]);
  assign byte8 = mode_ff[BYTE_SEL_POS];
  assign byte_evt = sync2_ff[0] ^ tgl_seen_ff;
  assign addr_evt = byte_evt & rx_is_addr;
  assign data_evt = byte_evt & ~rx_is_addr & (sel_ff != SEL_NONE);
  assign wr_evt = data_evt & wr_ff;
  assign rd_evt = data_evt & ~wr_ff;
  assign mode_wr = wr_evt & (sel_ff == SEL_MODE);
  assign mask_wr = wr_evt & (sel_ff == SEL_MASK);
  assign start_wr = wr_evt & (sel_ff == SEL_START);
  assign run_jam_wr = start_wr & (rx_byte[RUN_POS] | rx_byte[JAM_POS]);
  assign flag_wipe = mode_wr | mask_wr;
  assign status_rd = rd_evt & (sel_ff == SEL_STATUS);
  assign data_rd = rd_evt & (sel_ff == SEL_DATA);
  assign data_rd_lo = data_rd & (byte8 | hl_ff);
  assign abort_now = flag_wipe | run_jam_wr | data_rd;
  assign done_ok = conv_done & converting_ff & ~abort_now;
  assign done_hot = done_ok ? (8'h01 << conv_chan_ff) : 8'h00;
  assign new_fresh = fresh_ff | done_hot;
  assign all_now = (mask_ff != 8'h00) && ((new_fresh & mask_ff) == mask_ff);
  assign ptr_next = next_chan(ptr_ff, mask_ff);

  // frame selection; status stays selected for every read until ce falls
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sel_ff <= SEL_NONE;
      wr_ff <= 1'b0;
    end else if (addr_evt) begin
      wr_ff <= rx_byte[RW_BIT];
      if (rx_byte[6:0] <= ADDR_DATA_LAST) begin
        sel_ff <= SEL_DATA;
      end else if (rx_byte[6:0] == ADDR_MODE) begin
        sel_ff <= SEL_MODE;
      end else if (rx_byte[6:0] == ADDR_MASK) begin
        sel_ff <= SEL_MASK;
      end else if (rx_byte[6:0] == ADDR_START) begin
        sel_ff <= SEL_START;
      end else if (rx_byte[6:0] == ADDR_STATUS) begin
        sel_ff <= SEL_STATUS;
      end else begin
        sel_ff <= SEL_NONE;
      end
    end else if (!sync2_ff[1] && !byte_evt) begin
      sel_ff <= SEL_NONE;
    end
  end

  // host-written registers; idle mode drops run so nothing restarts
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_ff <= MODE_RESET;
      mask_ff <= MASK_RESET;
      run_ff <= 1'b0;
      jam_rb_ff <= 1'b0;
      ca_rb_ff <= 3'h0;
    end else begin
      if (mode_wr) begin
        mode_ff <= rx_byte[5:0];
        if (rx_byte[MODE_LSB+1:MODE_LSB] == 2'h0) begin
          run_ff <= 1'b0;
        end
      end
      if (mask_wr) begin
        mask_ff <= rx_byte;
      end
      if (start_wr) begin
        run_ff <= rx_byte[RUN_POS];
        jam_rb_ff <= rx_byte[JAM_POS];
        ca_rb_ff <= rx_byte[CA_LSB+2:CA_LSB];
      end
    end
  end

  // channel pointer and high/low byte select
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ptr_ff <= 3'h0;
      hl_ff <= 1'b0;
    end else if (start_wr && rx_byte[JAM_POS]) begin
      ptr_ff <= rx_byte[CA_LSB+2:CA_LSB];
      hl_ff <= rx_byte[HL_POS] & ~byte8;
    end else if (addr_evt && rx_byte[6:0] <= ADDR_DATA_LAST) begin
      hl_ff <= rx_byte[0] & ~byte8;
    end else if (data_rd) begin
      if (byte8) begin
        ptr_ff <= ptr_next;
      end else if (!hl_ff) begin
        hl_ff <= 1'b1;
      end else begin
        hl_ff <= 1'b0;
        ptr_ff <= ptr_next;
      end
    end else if (done_ok && (conv_mode == CONV_SCAN_ONCE || conv_mode == CONV_SCAN_LOOP)) begin
      ptr_ff <= ptr_next;
    end
  end

  // conversion sequencing: one start path fed by a pending request
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      converting_ff <= 1'b0;
      start_req_ff <= 1'b0;
      conv_start_ff <= 1'b0;
      conv_abort_ff <= 1'b0;
      conv_chan_ff <= 3'h0;
    end else begin
      conv_start_ff <= 1'b0;
      conv_abort_ff <= abort_now & converting_ff;
      if (abort_now || done_ok) begin
        converting_ff <= 1'b0;
      end
      if (mode_wr || mask_wr) begin
        start_req_ff <= 1'b0;
      end else if (start_wr) begin
        start_req_ff <= rx_byte[RUN_POS];
      end else if (data_rd_lo && conv_mode == CONV_SINGLE && run_ff) begin
        start_req_ff <= 1'b1;
      end else if (done_ok && run_ff && (conv_mode == CONV_SCAN_LOOP ||
                   (conv_mode == CONV_SCAN_ONCE && !all_now))) begin
        start_req_ff <= 1'b1;
      end else if (start_req_ff && !converting_ff) begin
        start_req_ff <= 1'b0;
        if (conv_mode != CONV_IDLE) begin
          conv_start_ff <= 1'b1;
          conv_chan_ff <= ptr_ff;
          converting_ff <= 1'b1;
        end
      end
    end
  end

  // busy: set at start, cleared at finish and by the listed host actions
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff <= 1'b0;
    end else if (start_req_ff && !converting_ff && conv_mode != CONV_IDLE && !abort_now && !start_wr) begin
      busy_ff <= 1'b1;
    end else if (done_ok || flag_wipe || run_jam_wr || data_rd) begin
      busy_ff <= 1'b0;
    end
  end

  // interrupt and all-done flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_flag_ff <= 1'b0;
      all_done_ff <= 1'b0;
    end else begin
      if (done_ok && (conv_mode == CONV_SINGLE || (conv_mode == CONV_SCAN_ONCE && all_now))) begin
        irq_flag_ff <= 1'b1;
      end else if (status_rd || data_rd || flag_wipe) begin
        irq_flag_ff <= 1'b0;
      end
      if (done_ok && all_now) begin
        all_done_ff <= 1'b1;
      end else if (data_rd || flag_wipe) begin
        all_done_ff <= 1'b0;
      end
    end
  end

  // per-channel fresh and overrun flags; start writes leave them alone
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fresh_ff <= '0;
      overrun_ff <= '0;
    end else begin
      for (int c = 0; c < NCHAN; c++) begin
        if (done_hot[c]) begin
          fresh_ff[c] <= 1'b1;
          if (fresh_ff[c] && (conv_mode == CONV_SINGLE || conv_mode == CONV_SCAN_LOOP)) begin
            overrun_ff[c] <= 1'b1;
          end
        end else if (flag_wipe || (data_rd_lo && ptr_ff == 3'(c))) begin
          fresh_ff[c] <= 1'b0;
          overrun_ff[c] <= 1'b0;
        end
      end
    end
  end

  // byte offered to the link, refreshed every cycle from live state
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_byte_ff <= 8'h00;
    end else begin
      unique case (sel_ff)
        SEL_STATUS: tx_byte_ff <= {irq_flag_ff, all_done_ff, busy_ff, 1'b0, ptr_ff, 1'b0};
        SEL_DATA: begin
          if (byte8 || hl_ff) begin
            tx_byte_ff <= rd_data[7:0];
          end else begin
            tx_byte_ff <= {fresh_ff[ptr_ff], overrun_ff[ptr_ff], 4'h0, rd_data[9:8]};
          end
        end
        SEL_MODE: tx_byte_ff <= {2'h0, mode_ff};
        SEL_MASK: tx_byte_ff <= mask_ff;
        SEL_START: tx_byte_ff <= {run_ff, 2'h0, jam_rb_ff, ca_rb_ff, hl_ff};
        SEL_NONE: tx_byte_ff <= 8'h00;
      endcase
    end
  end

  // pin pulls low only when allowed and due; the flag itself ignores the allow bit
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_drive_ff <= 1'b0;
    end else begin
      irq_drive_ff <= mode_ff[IRQ_ALLOW_POS] & irq_flag_ff &
                      (conv_mode == CONV_SINGLE || conv_mode == CONV_SCAN_ONCE);
    end
  end

  // converter side controls, all from flops
  assign irq_n_out = 1'b0;
  assign irq_n_oe_b = ~irq_drive_ff;
  assign conv_start = conv_start_ff;
  assign conv_abort = conv_abort_ff;
  assign conv_chan = conv_chan_ff;
  assign conv_byte_mode = byte8;
  assign conv_vref_sel = mode_ff[VREF_POS];
  assign conv_clk_en = (conv_mode != CONV_IDLE);
  assign osc_run = mode_ff[OSC_SEL_POS] & converting_ff;
endmodule
`default_nettype wire

/* verif/asr_host_model.sv */
// Purpose: serial bus master standing in for the host microcontroller
// Assumes: sck idles low, mosi sampled on rising sck, msb first
// Notes: sck only runs inside frames; 1600 ns gap before each byte
`timescale 1ns/1ps
`default_nettype none
module asr_host_model (
  output logic sck,
  output logic ce,
  output logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe_b,
  output logic [7:0] rx_data,
  output logic rx_stb
);
  logic miso_last;
  wire miso_line;
  // a released line shows the inverse of its last value, so a stale bit never matches by luck
  assign miso_line = miso_oe_b ? ~miso_last : miso_out;
  // idle levels at time zero
  initial begin
    sck = 1'b0;
    ce = 1'b0;
    mosi = 1'b0;
    rx_data = 8'h00;
    rx_stb = 1'b0;
    miso_last = 1'b0;
  end
  // one byte; the long gap lets the device fetch its answer across domains
  task automatic xfer(input logic [7:0] tx, input logic rd);
    logic [7:0] rx;
    #1600;
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #6;
      // sample just before the rising edge, the bit has stood since the last falling edge
      rx[i] = miso_line;
      miso_last = miso_line;
      sck = 1'b1;
      #6;
      sck = 1'b0;
    end
    if (rd) begin
      rx_data = rx;
      rx_stb = 1'b1;
      #1;
      rx_stb = 1'b0;
    end
  endtask
  task automatic frame_on();
    #3;
    ce = 1'b1;
  endtask
  task automatic frame_off();
    #1600;
    ce = 1'b0;
    #200;
  endtask
endmodule
`default_nettype wire

/* verif/asr_top_properties.sv */
// Purpose: port-level checks for the converter status and result sequencer
// Assumes: converter answers on clk_sys, one channel in flight at a time
// Notes: bound to every asr_top instance at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module asr_top_properties
  import asr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sck,
  input wire logic ce,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe_b,
  input wire logic irq_n_out,
  input wire logic irq_n_oe_b,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic [2:0] conv_chan,
  input wire logic conv_byte_mode,
  input wire logic conv_vref_sel,
  input wire logic conv_clk_en,
  input wire logic osc_run,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_result
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // a start is a single-cycle strobe
  sequence s_start_pulse;
    conv_start ##1 !conv_start;
  endsequence
  // the pin may only drop shortly after a finished conversion, since the flag sits in between
  sequence s_done_recent;
    $past(conv_done) || $past(conv_done, 2) || $past(conv_done, 3);
  endsequence
  chk_rst_quiet: assert property ($rose(rst_b) |-> irq_n_oe_b && !conv_clk_en && !osc_run)
    else $error("outputs active after reset release");
  chk_start_mode: assert property (conv_start |-> conv_clk_en)
    else $error("conversion started in idle mode");
  chk_start_pulse: assert property (conv_start |-> s_start_pulse)
    else $error("start strobe longer than one cycle");
  chk_idle_float: assert property (!conv_clk_en [*2] |-> irq_n_oe_b)
    else $error("interrupt pin driven in idle mode");
  chk_idle_osc: assert property (!conv_clk_en [*2] |-> !osc_run)
    else $error("oscillator running in idle mode");
  chk_pin_level: assert property (!irq_n_oe_b |-> !irq_n_out)
    else $error("interrupt pin driven high");
  chk_pin_cause: assert property ($fell(irq_n_oe_b) |-> s_done_recent)
    else $error("interrupt pin pulled without a finished conversion");
  chk_osc_start: assert property ($rose(osc_run) |-> conv_start || $past(conv_start))
    else $error("oscillator started without a conversion");
endmodule
bind asr_top asr_top_properties u_props (.clk_sys(clk_sys), .rst_b(rst_b), .sck(sck), .ce(ce), .mosi(mosi),
  .miso_out(miso_out), .miso_oe_b(miso_oe_b), .irq_n_out(irq_n_out), .irq_n_oe_b(irq_n_oe_b),
  .conv_start(conv_start), .conv_abort(conv_abort), .conv_chan(conv_chan), .conv_byte_mode(conv_byte_mode),
  .conv_vref_sel(conv_vref_sel), .conv_clk_en(conv_clk_en), .osc_run(osc_run), .conv_done(conv_done),
  .conv_result(conv_result));
`default_nettype wire

/* verif/asr_top_tb.sv */
// Purpose: self-checking bench for the converter status and result sequencer
// Assumes: host model drives the link, a behavioural converter answers starts
// Notes: modes 0 and 1 only; conversion results are random
`timescale 1ns/1ps
`default_nettype none
module asr_top_tb
  import asr_pkg::*;
;
  logic clk_sys, rst_b, sck, ce, mosi, miso_out, miso_oe_b, irq_n_out, irq_n_oe_b, conv_start, conv_abort;
  logic conv_byte_mode, conv_vref_sel, conv_clk_en, osc_run, rx_stb;
  logic conv_done = 1'b0;
  logic busy_m = 1'b0;
  logic abort_seen = 1'b0;
  logic [2:0] conv_chan, ch_m;
  logic [RES_W-1:0] conv_result = '0;
  logic [RES_W-1:0] r;
  logic [RES_W-1:0] res [NCHAN];
  logic [7:0] rx_data;
  logic [7:0] exp_q [$];
  logic [2:0] chan_q [$];
  int fails, compares, cnt;
  integer seed = 32'h412e75fb;
  // system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  asr_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .sck(sck), .ce(ce), .mosi(mosi), .miso_out(miso_out),
    .miso_oe_b(miso_oe_b), .irq_n_out(irq_n_out), .irq_n_oe_b(irq_n_oe_b), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_chan(conv_chan), .conv_byte_mode(conv_byte_mode),
    .conv_vref_sel(conv_vref_sel), .conv_clk_en(conv_clk_en), .osc_run(osc_run), .conv_done(conv_done),
    .conv_result(conv_result));
  asr_host_model host (.sck(sck), .ce(ce), .mosi(mosi), .miso_out(miso_out), .miso_oe_b(miso_oe_b),
    .rx_data(rx_data), .rx_stb(rx_stb));
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // every byte the host hears is matched against the oldest note
  always @(posedge rx_stb) begin
    cmp_byte(rx_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
  end
  // behavioural converter: answers a start after 120 cycles unless aborted first
  always @(posedge clk_sys) begin
    logic fin;
    fin = 1'b0;
    if (conv_abort && busy_m) begin
      busy_m = 1'b0;
      abort_seen = 1'b1;
    end
    if (conv_start) begin
      cmp_byte({5'h00, conv_chan}, {5'h00, chan_q.size() > 0 ? chan_q.pop_front() : 3'bxxx});
      busy_m = 1'b1;
      ch_m = conv_chan;
      cnt = 120;
    end else if (busy_m) begin
      cnt--;
      if (cnt == 0) begin
        r = RES_W'($random(seed));
        if (conv_byte_mode) r[9:8] = 2'b00;
        res[ch_m] = r;
        conv_result <= r;
        fin = 1'b1;
        busy_m = 1'b0;
      end
    end
    conv_done <= fin;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.frame_on();
    host.xfer({1'b1, a}, 1'b0);
    host.xfer(d, 1'b0);
    host.frame_off();
  endtask
  task automatic rd(input logic [6:0] a, input int n, input logic [7:0] e0, input logic [7:0] e1);
    exp_q.push_back(e0);
    if (n == 2) exp_q.push_back(e1);
    host.frame_on();
    host.xfer({1'b0, a}, 1'b0);
    repeat (n) host.xfer(8'h00, 1'b1);
    host.frame_off();
  endtask
  // bounded wait for the converter to finish, then let the flags land
  task automatic wait_done();
    int n;
    n = 0;
    while (conv_done !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    if (conv_done !== 1'b1) begin
      fails++;
      print_verdict();
    end else begin
      repeat (4) @(posedge clk_sys);
    end
  endtask
  // main sequence: idle, single conversions in 10-bit and 8-bit, then back to idle mid-conversion
  initial begin
    rst_b = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(ADDR_STATUS, 2, 8'h00, 8'h00);
    rd(7'h15, 1, 8'h00, 8'h00);
    wr(ADDR_MODE, 8'h21);
    wr(ADDR_MASK, 8'h05);
    chan_q.push_back(3'd0);
    wr(ADDR_START, 8'h90);
    cmp_bit(osc_run, 1'b1);
    rd(ADDR_STATUS, 1, 8'h20, 8'h00);
    wait_done();
    cmp_bit(irq_n_oe_b, 1'b1);
    rd(ADDR_STATUS, 2, 8'h80, 8'h00);
    repeat (2) begin
      chan_q.push_back(3'd2);
      wr(ADDR_START, 8'h94);
      wait_done();
    end
    rd(ADDR_STATUS, 1, 8'hc4, 8'h00);
    chan_q.push_back(3'd0);
    rd(7'h04, 2, {2'b11, 4'h0, res[2][9:8]}, res[2][7:0]);
    wait_done();
    rd(ADDR_STATUS, 1, 8'h80, 8'h00);
    wr(ADDR_MODE, 8'h2d);
    cmp_bit(conv_byte_mode, 1'b1);
    chan_q.push_back(3'd0);
    wr(ADDR_START, 8'h90);
    wait_done();
    cmp_bit(irq_n_oe_b, 1'b0);
    chan_q.push_back(3'd2);
    rd(7'h01, 1, res[0][7:0], 8'h00);
    cmp_bit(irq_n_oe_b, 1'b1);
    wr(ADDR_MODE, 8'h00);
    repeat (8) @(posedge clk_sys);
    cmp_bit(abort_seen, 1'b1);
    cmp_bit(conv_clk_en, 1'b0);
    cmp_bit(osc_run, 1'b0);
    cmp_byte(8'(exp_q.size()), 8'h00);
    cmp_byte(8'(chan_q.size()), 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
